/* src/drive_input_pkg.sv */
// Package of function codes and timing constants for the input command decoder
`default_nettype none
package drive_input_pkg;
  // Function codes that a terminal may be assigned
  localparam logic [7:0] CODE_START        = 8'h14;  // 20
  localparam logic [7:0] CODE_STOP         = 8'h15;  // 21
  localparam logic [7:0] CODE_DIRECTION    = 8'h16;  // 22
  localparam logic [7:0] CODE_PID_DISABLE  = 8'h17;  // 23
  localparam logic [7:0] CODE_PID_RESET    = 8'h18;  // 24
  localparam logic [7:0] CODE_SPEED_RAISE  = 8'h1B;  // 27
  localparam logic [7:0] CODE_SPEED_LOWER  = 8'h1C;  // 28
  localparam logic [7:0] CODE_MEM_CLEAR    = 8'h1D;  // 29
  localparam logic [7:0] CODE_OPERATOR     = 8'h1F;  // 31
  localparam logic [7:0] CODE_PRESET_BIT1  = 8'h20;  // 32, bits 2..4 follow in order
  // Clear enable setting value that permits the memory clear
  localparam logic [1:0] CLEAR_ENABLE_VAL  = 2'h0;
  // Source code that selects the built-in operator
  localparam logic [3:0] OPERATOR_SOURCE   = 4'h2;
  // Raise/lower step interval
  localparam int         CLK_PERIOD_NS     = 100;
  localparam int         RAMP_STEP_TIME_US = 100;
  localparam int         RAMP_STEP_CYCLES  = (RAMP_STEP_TIME_US * 1000) / CLK_PERIOD_NS;
  // Reset values
  localparam logic       DIR_RESET_FWD     = 1'b1;
endpackage : drive_input_pkg
`default_nettype wire

/* src/raise_lower_memory.sv */
// Stored raise/lower frequency with stepping and clear
`default_nettype none
module raise_lower_memory
  import drive_input_pkg::*;
#(
  parameter int FREQ_W     = 16,
  parameter int STEP_CYCLES = RAMP_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Frequency sources
  input  wire logic [FREQ_W-1:0] presentFreq,
  input  wire logic [FREQ_W-1:0] setFreq,
  // Commands
  input  wire logic              raise,
  input  wire logic              lower,
  input  wire logic              clear,
  // Stored value
  output logic [FREQ_W-1:0]      freq_r
);
  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STEP_CYCLES - 1);
  localparam logic [FREQ_W-1:0] FREQ_MAX = '1;

  logic             active_r;
  logic [CNT_W-1:0] cnt_r;
  logic             moving;
  logic             tick;

  assign moving = raise ^ lower;  // Both at once cancel out
  assign tick   = (cnt_r == CNT_LAST);

  // Step prescaler, restarts with each new movement
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (!moving || !active_r || tick) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Movement tracker so the first cycle picks up the live frequency
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= 1'b0;
    end else begin
      active_r <= moving && !clear;
    end
  end

  // Stored value: clear first, then the start point, then saturating steps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_r <= '0;
    end else if (clear) begin
      freq_r <= setFreq;
    end else if (moving && !active_r) begin
      freq_r <= presentFreq;
    end else if (moving && tick) begin
      if (raise && freq_r != FREQ_MAX) begin
        freq_r <= freq_r + 1'b1;
      end else if (lower && freq_r != '0) begin
        freq_r <= freq_r - 1'b1;
      end
    end
  end
endmodule : raise_lower_memory
`default_nettype wire

/* src/drive_input_command_decoder.sv */
// Decoder of input terminal functions into drive control commands
// Overview of operation
// - Start terminal turning on starts the motor; off leaves run state alone.
// - Stop terminal on stops the motor; off leaves run state alone.
// - Direction terminal on selects forward, off selects reverse.
// - Direction change while turning decelerates first, then reverses.
// - PID disable on with PID enabled suspends the closed loop.
// - PID disable off lets the loop run whenever PID is enabled.
// - PID reset terminal on forces the integrator to zero.
// - Raise terminal on raises frequency from the present frequency.
// - Lower terminal on lowers frequency from the present frequency.
// - Memory clear on loads the stored frequency from the set frequency.
// - Memory clear acts only when its enable setting equals 00.
// - Memory clear off leaves the stored raise/lower frequency unchanged.
// - Override on takes frequency and run command from the operator.
// - Override off uses the configured frequency and run sources.
// - Preset speed terminals give select bits 1 to 4, on means one.
`default_nettype none
module drive_input_command_decoder
  import drive_input_pkg::*;
#(
  parameter int NUM_TERMS = 7,
  parameter int FREQ_W    = 16,
  parameter int SRC_W     = 4
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // Terminals and their assigned function codes
  input  wire logic [NUM_TERMS-1:0]      termIn,
  input  wire logic [NUM_TERMS-1:0][7:0] termCode,
  // Configuration
  input  wire logic                      pidEnableCfg,
  input  wire logic [1:0]                clearEnableCfg,
  input  wire logic [SRC_W-1:0]          freqSourceCfg,
  input  wire logic [SRC_W-1:0]          runSourceCfg,
  input  wire logic [FREQ_W-1:0]         setFrequencyParameter,
  // Status from the control core
  input  wire logic                      motorTurning,
  input  wire logic [FREQ_W-1:0]         presentFreq,
  // Motion commands
  output logic                           runCmd_r,
  output logic                           dirFwd_r,
  output logic                           reverseDecel_r,
  // PID commands
  output logic                           pidRun_r,
  output logic                           pidSuspend_r,
  output logic                           loopIntegratorClear_r,
  // Speed adjust
  output logic                           speedRaise_r,
  output logic                           speedLower_r,
  output logic [FREQ_W-1:0]              raiseLowerFreq_r,
  // Source selection and preset speed
  output logic                           operatorSourceOverride_r,
  output logic [SRC_W-1:0]               freqSourceSel_r,
  output logic [SRC_W-1:0]               runSourceSel_r,
  output logic [3:0]                     presetSpeedSel_r
);
  typedef enum logic {DIR_HOLD, DIR_DECEL} dir_state_e;

  // True when any terminal carrying the given code is on
  function automatic logic termOn(input logic [NUM_TERMS-1:0] lvl,
                                  input logic [NUM_TERMS-1:0][7:0] codes,
                                  input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++) begin
      hit = hit | (lvl[i] & (codes[i] == code));
    end
    return hit;
  endfunction : termOn

  logic       threeWireStart;
  logic       threeWireStop;
  logic       dirReq;
  logic       pidDisableOn;
  logic       integClearOn;
  logic       raiseOn;
  logic       speedLower;
  logic       memClearOn;
  logic       memClearEff;
  logic       overrideOn;
  logic [3:0] presetBits;
  logic       startPrev_r;
  logic       startRise;
  dir_state_e dirState_r;

  // Function decode by assigned code only
  always_comb begin
    threeWireStart = termOn(termIn, termCode, CODE_START);
    threeWireStop  = termOn(termIn, termCode, CODE_STOP);
    dirReq         = termOn(termIn, termCode, CODE_DIRECTION);
    pidDisableOn   = termOn(termIn, termCode, CODE_PID_DISABLE);
    integClearOn   = termOn(termIn, termCode, CODE_PID_RESET);
    raiseOn        = termOn(termIn, termCode, CODE_SPEED_RAISE);
    speedLower     = termOn(termIn, termCode, CODE_SPEED_LOWER);
    memClearOn     = termOn(termIn, termCode, CODE_MEM_CLEAR);
    overrideOn     = termOn(termIn, termCode, CODE_OPERATOR);
    for (int b = 0; b < 4; b++) begin
      presetBits[b] = termOn(termIn, termCode, CODE_PRESET_BIT1 + 8'(b));
    end
  end

  // Start acts on the turn-on edge so a held start cannot defeat a later stop
  assign startRise   = threeWireStart && !startPrev_r;
  assign memClearEff = memClearOn && (clearEnableCfg == CLEAR_ENABLE_VAL);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startPrev_r <= 1'b0;
    end else begin
      startPrev_r <= threeWireStart;
    end
  end

  // Run latch; stop wins over a simultaneous start for safety
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      runCmd_r <= 1'b0;
    end else if (threeWireStop) begin
      runCmd_r <= 1'b0;
    end else if (startRise) begin
      runCmd_r <= 1'b1;
    end
  end

  // Direction: follow at rest, decelerate to standstill before reversing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dirState_r     <= DIR_HOLD;
      dirFwd_r       <= DIR_RESET_FWD;
      reverseDecel_r <= 1'b0;
    end else begin
      case (dirState_r)
        DIR_HOLD: begin
          if (dirReq != dirFwd_r && motorTurning) begin
            dirState_r     <= DIR_DECEL;
            reverseDecel_r <= 1'b1;
          end else begin
            dirFwd_r <= dirReq;
          end
        end
        DIR_DECEL: begin
          if (!motorTurning) begin
            dirState_r     <= DIR_HOLD;
            reverseDecel_r <= 1'b0;
            dirFwd_r       <= dirReq;
          end else if (dirReq == dirFwd_r) begin
            dirState_r     <= DIR_HOLD;  // Request withdrawn, resume
            reverseDecel_r <= 1'b0;
          end
        end
        default: begin
          dirState_r <= DIR_HOLD;
        end
      endcase
    end
  end

  // PID control commands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pidRun_r              <= 1'b0;
      pidSuspend_r          <= 1'b0;
      loopIntegratorClear_r <= 1'b0;
    end else begin
      pidSuspend_r          <= pidEnableCfg && pidDisableOn;
      pidRun_r              <= pidEnableCfg && !pidDisableOn;
      loopIntegratorClear_r <= integClearOn;
    end
  end

  // Speed adjust levels to the ramp logic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      speedRaise_r <= 1'b0;
      speedLower_r <= 1'b0;
    end else begin
      speedRaise_r <= raiseOn && !speedLower;
      speedLower_r <= speedLower && !raiseOn;
    end
  end

  // Stored raise/lower frequency
  raise_lower_memory #(
    .FREQ_W      (FREQ_W),
    .STEP_CYCLES (RAMP_STEP_CYCLES)
  ) u_memory (
    .clk         (clk),
    .rst_b       (rst_b),
    .presentFreq (presentFreq),
    .setFreq     (setFrequencyParameter),
    .raise       (raiseOn),
    .lower       (speedLower),
    .clear       (memClearEff),
    .freq_r      (raiseLowerFreq_r)
  );

  // Source selection and preset speed bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      operatorSourceOverride_r <= 1'b0;
      freqSourceSel_r          <= '0;
      runSourceSel_r           <= '0;
      presetSpeedSel_r         <= '0;
    end else begin
      operatorSourceOverride_r <= overrideOn;
      freqSourceSel_r  <= overrideOn ? SRC_W'(OPERATOR_SOURCE) : freqSourceCfg;
      runSourceSel_r   <= overrideOn ? SRC_W'(OPERATOR_SOURCE) : runSourceCfg;
      presetSpeedSel_r <= presetBits;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_start_runs: assert property (startRise && !threeWireStop |=> runCmd_r)
    else $error("start edge did not start the motor");
  chk_stop_halts: assert property (threeWireStop |=> !runCmd_r)
    else $error("stop did not stop the motor");
  chk_run_holds: assert property (!startRise && !threeWireStop |=> $stable(runCmd_r))
    else $error("run state changed with no command");
  chk_dir_follow: assert property (
    dirState_r == DIR_HOLD && !motorTurning |=> dirFwd_r == $past(dirReq))
    else $error("direction did not follow the terminal at rest");
  chk_reverse_waits: assert property (
    dirState_r == DIR_DECEL && motorTurning && dirReq != dirFwd_r
    |=> $stable(dirFwd_r) && reverseDecel_r)
    else $error("direction changed before standstill");
  chk_pid_suspend: assert property (
    1'b1 |=> pidSuspend_r == $past(pidEnableCfg && pidDisableOn))
    else $error("PID suspend wrong");
  chk_pid_normal: assert property (
    pidEnableCfg && !pidDisableOn |=> pidRun_r && !pidSuspend_r)
    else $error("PID loop not running");
  chk_integ_clear: assert property (integClearOn |=> loopIntegratorClear_r)
    else $error("integrator clear missing");
  chk_speed_adjust: assert property (
    1'b1 |=> speedRaise_r == $past(raiseOn && !speedLower)
    && speedLower_r == $past(speedLower && !raiseOn))
    else $error("raise or lower command wrong");
  chk_mem_clear: assert property (
    memClearOn && clearEnableCfg == CLEAR_ENABLE_VAL
    |=> raiseLowerFreq_r == $past(setFrequencyParameter))
    else $error("memory clear did not load set frequency");
  chk_mem_hold: assert property (
    !memClearEff && !raiseOn && !speedLower |=> $stable(raiseLowerFreq_r))
    else $error("stored frequency changed while idle");
  chk_clear_gated: assert property (
    memClearOn && clearEnableCfg != CLEAR_ENABLE_VAL && !raiseOn && !speedLower
    |=> $stable(raiseLowerFreq_r))
    else $error("memory clear acted while disabled");
  chk_op_override: assert property (
    overrideOn |=> freqSourceSel_r == SRC_W'(OPERATOR_SOURCE)
    && runSourceSel_r == SRC_W'(OPERATOR_SOURCE))
    else $error("override did not select operator");
  chk_cfg_source: assert property (
    !overrideOn |=> freqSourceSel_r == $past(freqSourceCfg)
    && runSourceSel_r == $past(runSourceCfg))
    else $error("configured source not used");
  chk_preset_bits: assert property (1'b1 |=> presetSpeedSel_r == $past(presetBits))
    else $error("preset speed bits wrong");

  cov_start_stop: cover property (startRise ##[1:20] threeWireStop);
  cov_reversal: cover property (dirState_r == DIR_DECEL ##[1:50] dirState_r == DIR_HOLD);
  cov_mem_clear: cover property (memClearEff ##1 raiseOn);
  cov_override: cover property (overrideOn ##1 !overrideOn);
endmodule : drive_input_command_decoder
`default_nettype wire

/* tb/drive_contact_model.sv */
// Model of the terminal contacts and of the motor that the decoder commands
`default_nettype none
module drive_contact_model #(
  parameter int LAG = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Contact requests from the bench
  input  wire logic [6:0] wantOn,
  output logic      [6:0] termIn,
  // Motor commands and state
  input  wire logic       runCmd_r,
  input  wire logic       reverseDecel_r,
  output logic            motorTurning
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       target;
  logic [7:0] lagCnt_r;

  // Contacts are plain levels; an open contact reads as off
  assign termIn = wantOn;

  // Motor wants to turn only on a run command that is not braking for reversal
  assign target = runCmd_r & ~reverseDecel_r;

  // Spin-up and coast-down both take LAG cycles, so reversal is never instant
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      motorTurning <= 1'b0;
      lagCnt_r     <= 8'h00;
    end else if (motorTurning == target) begin
      lagCnt_r <= 8'h00;
    end else if (lagCnt_r == 8'(LAG - 1)) begin
      motorTurning <= target;
      lagCnt_r     <= 8'h00;
    end else begin
      lagCnt_r <= lagCnt_r + 8'h01;
    end
  end
endmodule : drive_contact_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the input command decoder
`default_nettype none
module tb
  import drive_input_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic            clk;
  logic            rst_b;
  logic [6:0]      wantOn;
  logic [6:0]      termIn;
  logic [6:0][7:0] termCode;
  logic            pidEnableCfg;
  logic [1:0]      clearEnableCfg;
  logic [3:0]      freqSourceCfg;
  logic [3:0]      runSourceCfg;
  logic [15:0]     setFrequencyParameter;
  logic [15:0]     presentFreq;
  logic            motorTurning;
  logic            runCmd_r, dirFwd_r, reverseDecel_r;
  logic            pidRun_r, pidSuspend_r, loopIntegratorClear_r;
  logic            speedRaise_r, speedLower_r;
  logic [15:0]     raiseLowerFreq_r;
  logic            operatorSourceOverride_r;
  logic [3:0]      freqSourceSel_r, runSourceSel_r, presetSpeedSel_r;
  logic [15:0]     motion, pid, spd, src;
  int              bad_count;
  int              total_checks;

  // Outputs grouped so one compare covers a whole concern
  assign motion = {13'h0, runCmd_r, dirFwd_r, reverseDecel_r};
  assign pid    = {13'h0, pidRun_r, pidSuspend_r, loopIntegratorClear_r};
  assign spd    = {14'h0, speedRaise_r, speedLower_r};
  assign src    = {3'h0, operatorSourceOverride_r, freqSourceSel_r, runSourceSel_r,
                   presetSpeedSel_r};

  drive_contact_model model (.clk(clk), .rst_b(rst_b), .wantOn(wantOn), .termIn(termIn),
    .runCmd_r(runCmd_r), .reverseDecel_r(reverseDecel_r), .motorTurning(motorTurning));

  drive_input_command_decoder dut (.clk(clk), .rst_b(rst_b), .termIn(termIn),
    .termCode(termCode), .pidEnableCfg(pidEnableCfg), .clearEnableCfg(clearEnableCfg),
    .freqSourceCfg(freqSourceCfg), .runSourceCfg(runSourceCfg),
    .setFrequencyParameter(setFrequencyParameter), .motorTurning(motorTurning),
    .presentFreq(presentFreq), .runCmd_r(runCmd_r), .dirFwd_r(dirFwd_r),
    .reverseDecel_r(reverseDecel_r), .pidRun_r(pidRun_r), .pidSuspend_r(pidSuspend_r),
    .loopIntegratorClear_r(loopIntegratorClear_r), .speedRaise_r(speedRaise_r),
    .speedLower_r(speedLower_r), .raiseLowerFreq_r(raiseLowerFreq_r),
    .operatorSourceOverride_r(operatorSourceOverride_r),
    .freqSourceSel_r(freqSourceSel_r), .runSourceSel_r(runSourceSel_r),
    .presetSpeedSel_r(presetSpeedSel_r));

  // 10 MHz clock
  always #50 clk = ~clk;

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Inputs change at the falling edge, then one sampling edge passes
  task automatic press(input logic [6:0] m);
    wantOn = m;
    tick(1);
  endtask : press

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait on the motor model, a hang shows as a mismatch
  task automatic wait_turn(input logic lvl);
    for (int i = 0; i < 50 && motorTurning !== lvl; i++) tick(1);
    check({15'h0, motorTurning}, {15'h0, lvl});
  endtask : wait_turn

  task automatic test_done;
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the roughly 2060 cycles the tests need
  initial begin
    #(20000 * 100);
    bad_count++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    wantOn = 7'h04;
    termCode = {CODE_SPEED_LOWER, CODE_SPEED_RAISE, CODE_PID_RESET, CODE_PID_DISABLE,
                CODE_DIRECTION, CODE_STOP, CODE_START};
    pidEnableCfg = 1'b0;
    clearEnableCfg = 2'h1;
    freqSourceCfg = 4'h5;
    runSourceCfg = 4'h7;
    setFrequencyParameter = 16'h0A5C;
    presentFreq = 16'h0100;
    tick(8);
    check(motion, 16'h0002);
    check(pid | spd | src | raiseLowerFreq_r, 16'h0000);
    rst_b = 1'b1;
    tick(1);
    // Start latches, stop clears, both ignore their off level
    press(7'h05);
    check(motion, 16'h0006);
    press(7'h04);
    check(motion, 16'h0006);
    wait_turn(1'b1);
    // Reversal while turning brakes first
    press(7'h00);
    check(motion, 16'h0007);
    wait_turn(1'b0);
    check(motion, 16'h0007);
    tick(1);
    check(motion, 16'h0004);
    press(7'h02);
    check(motion, 16'h0000);
    press(7'h00);
    check(motion, 16'h0000);
    wait_turn(1'b0);
    press(7'h04);
    check(motion, 16'h0002);
    // Stop dominates a simultaneous start, and a held start does not restart
    press(7'h07);
    check(motion, 16'h0002);
    press(7'h05);
    check(motion, 16'h0002);
    // Every combination of loop enable and suspend terminal
    for (int k = 0; k < 4; k++) begin
      pidEnableCfg = k[1];
      press({3'h0, k[0], 3'h4});
      check(pid, {13'h0, k[1] & ~k[0], k[1] & k[0], 1'b0});
    end
    pidEnableCfg = 1'b0;
    press(7'h14);
    check(pid, 16'h0001);
    press(7'h04);
    check(pid, 16'h0000);
    // Raise from the present frequency, one step per 1000 cycles
    press(7'h24);
    check(raiseLowerFreq_r, 16'h0100);
    check(spd, 16'h0002);
    tick(999);
    check(raiseLowerFreq_r, 16'h0100);
    tick(1);
    check(raiseLowerFreq_r, 16'h0101);
    press(7'h64);
    tick(3);
    check(spd, 16'h0000);
    check(raiseLowerFreq_r, 16'h0101);
    presentFreq = 16'h0080;
    press(7'h44);
    check(raiseLowerFreq_r, 16'h0080);
    check(spd, 16'h0001);
    tick(1000);
    check(raiseLowerFreq_r, 16'h007F);
    press(7'h04);
    tick(5);
    check(raiseLowerFreq_r, 16'h007F);
    // Memory clear works only with its enable setting at zero
    termCode[6] = CODE_MEM_CLEAR;
    press(7'h44);
    check(raiseLowerFreq_r, 16'h007F);
    clearEnableCfg = 2'h0;
    tick(1);
    check(raiseLowerFreq_r, 16'h0A5C);
    press(7'h04);
    setFrequencyParameter = 16'h0BEE;
    tick(3);
    check(raiseLowerFreq_r, 16'h0A5C);
    // Operator override of both sources
    termCode[0] = CODE_OPERATOR;
    press(7'h04);
    check(src, {4'h0, 4'h5, 4'h7, 4'h0});
    press(7'h05);
    check(src, {4'h1, OPERATOR_SOURCE, OPERATOR_SOURCE, 4'h0});
    // Preset bits on four terminals, the rest carry an unused code
    for (int i = 0; i < 4; i++) termCode[i] = CODE_PRESET_BIT1 + 8'(i);
    for (int i = 4; i < 7; i++) termCode[i] = 8'h13;
    for (int i = 0; i < 6; i++) begin
      press({3'h7, 4'(i == 5 ? 15 : 1 << i)});
      check(src, {4'h0, 4'h5, 4'h7, 4'(i == 5 ? 15 : 1 << i)});
      check(pid | spd | motion, 16'h0000);
    end
    test_done();
  end
endmodule : tb
`default_nettype wire
